// file: sxd_pkg.sv
// package for the stack extension decode block: constants, opcodes, register map
package sxd_pkg;
	localparam int ADDR_W = 12;
	localparam int PC_W = 21;
	localparam logic [7:0] PUSH_LITERAL_HI = 8'hfa;
	localparam logic [7:0] SUB_POINTER_HI = 8'he9;
	localparam logic [1:0] SEL_STACK_RETURN = 2'h3;
	localparam logic [1:0] SEL_STACK_PTR = 2'h2;
	localparam logic [1:0] SEL_PTR0 = 2'h0;
	localparam logic [1:0] SEL_PTR1 = 2'h1;
	localparam logic [11:0] PTR_STEP = 12'h001;
	localparam logic [7:0] OFFSET_LIMIT = 8'h5f;
	localparam logic [11:0] ACCESS_HI_BASE = 12'hf00;
	localparam logic [11:0] PTR_RESET = 12'h000;
	// apb register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_INSN = 8'h04;
	localparam logic [7:0] REG_PTR0 = 8'h08;
	localparam logic [7:0] REG_PTR1 = 8'h0c;
	localparam logic [7:0] REG_PTR2 = 8'h10;
	localparam logic [7:0] REG_BANK = 8'h14;
	localparam logic [7:0] REG_RET_TOP = 8'h18;
	localparam logic [7:0] REG_PC = 8'h1c;
	localparam logic [7:0] REG_EADDR = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h24;
	localparam int CTRL_EXT_BIT = 0;
	localparam int INSN_W = 16;
	typedef enum logic [1:0] {ST_IDLE, ST_RET_NOP} sxd_state_t;
endpackage : sxd_pkg

// file: sxd_stack_decode.sv
// stack extension decode: executes push/sub-pointer/sub-return and forms indexed effective addresses
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sxd_stack_decode (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	output var logic mem_we,
	output var logic [sxd_pkg::ADDR_W-1:0] mem_addr,
	output var logic [7:0] mem_wdata,
	output var logic [sxd_pkg::ADDR_W-1:0] eff_addr,
	output var logic dest_to_file,
	output var logic pc_load,
	output var logic [sxd_pkg::PC_W-1:0] pc_out
);
	import sxd_pkg::*;

	typedef struct packed {
		logic ext_set_cfg_bit;
		logic [ADDR_W-1:0] ptr0;
		logic [ADDR_W-1:0] ptr1;
		logic [ADDR_W-1:0] stack_pointer_reg;
		logic [3:0] bank_select_reg;
		logic [PC_W-1:0] return_stack_top;
		logic [PC_W-1:0] pc;
		logic [INSN_W-1:0] insn;
		sxd_state_t state;
		logic busy;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic mem_we;
		logic [ADDR_W-1:0] mem_addr;
		logic [7:0] mem_wdata;
		logic [ADDR_W-1:0] eff_addr;
		logic dest_to_file;
		logic pc_load;
	} sxd_regs_t;

	sxd_regs_t s_reg;
	sxd_regs_t s_next;

	logic setup;
	logic acc_wr;
	logic [7:0] k8;
	logic [ADDR_W-1:0] k6;
	logic [ADDR_W-1:0] operand_addr;

	always_comb begin
		s_next = s_reg;
		setup = psel && !penable;
		acc_wr = psel && penable && pwrite;
		k8 = s_reg.insn[7:0];
		k6 = {6'h00, s_reg.insn[5:0]};
		operand_addr = '0;
		s_next.mem_we = 1'b0;
		s_next.pc_load = 1'b0;
		s_next.pready = setup;
		// refusal is decided at setup so that it stands beside pready
		s_next.pslverr = setup && (paddr > REG_STATUS || paddr[1:0] != 2'h0);

		// effective address for a byte/bit operand held in insn[7:0], access bit insn[8], dest insn[9]
		if (s_reg.insn[8]) begin
			operand_addr = {s_reg.bank_select_reg, k8};
		end else if (s_reg.ext_set_cfg_bit && k8 <= OFFSET_LIMIT) begin
			// a zero stack pointer yields offsets 00h..5fh, the plain access ram
			operand_addr = ADDR_W'(s_reg.stack_pointer_reg + {4'h0, k8});
		end else if (k8 <= OFFSET_LIMIT) begin
			operand_addr = {4'h0, k8};
		end else begin
			operand_addr = ACCESS_HI_BASE | {4'h0, k8};
		end
		s_next.eff_addr = operand_addr;
		s_next.dest_to_file = s_reg.insn[9];

		// instruction issue: a write to the instruction register starts execution
		case (s_reg.state)
			ST_IDLE: begin
				if (s_reg.busy) begin
					s_next.busy = 1'b0;
					if (s_reg.ext_set_cfg_bit && s_reg.insn[15:8] == PUSH_LITERAL_HI) begin
						s_next.mem_we = 1'b1;
						s_next.mem_addr = s_reg.stack_pointer_reg;
						s_next.mem_wdata = k8;
						s_next.stack_pointer_reg = s_reg.stack_pointer_reg - PTR_STEP;
					end else if (s_reg.ext_set_cfg_bit && s_reg.insn[15:8] == SUB_POINTER_HI) begin
						// no status flag exists here; the subtract never touches flags
						case (s_reg.insn[7:6])
							SEL_PTR0: s_next.ptr0 = s_reg.ptr0 - k6;
							SEL_PTR1: s_next.ptr1 = s_reg.ptr1 - k6;
							SEL_STACK_PTR: s_next.stack_pointer_reg = s_reg.stack_pointer_reg - k6;
							default: begin
								s_next.stack_pointer_reg = s_reg.stack_pointer_reg - k6;
								s_next.pc = s_reg.return_stack_top;
								s_next.pc_load = 1'b1;
								s_next.state = ST_RET_NOP;
							end
						endcase
					end
				end
			end
			ST_RET_NOP: begin
				s_next.state = ST_IDLE;
			end
			default: s_next.state = ST_IDLE;
		endcase

		// apb: no wait state, read data is captured at setup, writes take effect in the access phase
		if (setup) begin
			if (paddr == REG_CTRL) begin
				s_next.prdata = {31'h0, s_reg.ext_set_cfg_bit};
			end else if (paddr == REG_INSN) begin
				s_next.prdata = {16'h0, s_reg.insn};
			end else if (paddr == REG_PTR0) begin
				s_next.prdata = {20'h0, s_reg.ptr0};
			end else if (paddr == REG_PTR1) begin
				s_next.prdata = {20'h0, s_reg.ptr1};
			end else if (paddr == REG_PTR2) begin
				s_next.prdata = {20'h0, s_reg.stack_pointer_reg};
			end else if (paddr == REG_BANK) begin
				s_next.prdata = {28'h0, s_reg.bank_select_reg};
			end else if (paddr == REG_RET_TOP) begin
				s_next.prdata = {11'h0, s_reg.return_stack_top};
			end else if (paddr == REG_PC) begin
				s_next.prdata = {11'h0, s_reg.pc};
			end else if (paddr == REG_EADDR) begin
				s_next.prdata = {20'h0, s_reg.eff_addr};
			end else if (paddr == REG_STATUS) begin
				s_next.prdata = {30'h0, s_reg.state == ST_RET_NOP, s_reg.busy};
			end else begin
				s_next.prdata = 32'h0;
			end
		end
		if (psel && penable && s_reg.pready) begin
			s_next.pready = 1'b0;
			if (acc_wr && !s_reg.pslverr) begin
				if (paddr == REG_CTRL) begin
					s_next.ext_set_cfg_bit = pwdata[CTRL_EXT_BIT];
				end else if (paddr == REG_INSN) begin
					// a new instruction while one is in flight is dropped
					if (!s_reg.busy && s_reg.state == ST_IDLE) begin
						s_next.insn = pwdata[INSN_W-1:0];
						s_next.busy = 1'b1;
					end
				end else if (paddr == REG_PTR0) begin
					s_next.ptr0 = pwdata[ADDR_W-1:0];
				end else if (paddr == REG_PTR1) begin
					s_next.ptr1 = pwdata[ADDR_W-1:0];
				end else if (paddr == REG_PTR2) begin
					s_next.stack_pointer_reg = pwdata[ADDR_W-1:0];
				end else if (paddr == REG_BANK) begin
					s_next.bank_select_reg = pwdata[3:0];
				end else if (paddr == REG_RET_TOP) begin
					s_next.return_stack_top = pwdata[PC_W-1:0];
				end else if (paddr == REG_PC) begin
					s_next.pc = pwdata[PC_W-1:0];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0; // extension disabled out of reset
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign mem_we = s_reg.mem_we;
	assign mem_addr = s_reg.mem_addr;
	assign mem_wdata = s_reg.mem_wdata;
	assign eff_addr = s_reg.eff_addr;
	assign dest_to_file = s_reg.dest_to_file;
	assign pc_load = s_reg.pc_load;
	assign pc_out = s_reg.pc;
endmodule // sxd_stack_decode
`default_nettype wire

// file: sxd_monitor.sv
// port checker for the stack extension decode block
`timescale 1ns/1ps
`default_nettype none
module sxd_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic mem_we,
	input wire logic dest_to_file,
	input wire logic pc_load,
	input wire logic [7:0] paddr,
	input wire logic [7:0] mem_wdata,
	input wire logic [31:0] pwdata,
	input wire logic [sxd_pkg::ADDR_W-1:0] eff_addr
);
	import sxd_pkg::*;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic iw = pready & pwrite & (paddr == REG_INSN);
	a_push_store: assert property (mem_we |->
		$past(iw && pwdata[15:8] == 8'hfa, 2) && mem_wdata == $past(pwdata[7:0], 2)) else $error("push");
	a_push_pulse: assert property (mem_we |=> !mem_we) else $error("pulse");
	a_ret_cause: assert property (pc_load |-> $past(iw && pwdata[15:6] == 10'h3a7, 2)) else $error("ret");
	a_ret_idle: assert property (pc_load |=> !pc_load && !mem_we) else $error("nop");
	a_dest_bit: assert property (iw |-> ##2 dest_to_file == $past(pwdata[9], 2)) else $error("dest");
	a_high_lit: assert property (iw && !pwdata[8] && pwdata[7:0] > 8'h5f |->
		##2 eff_addr == {4'hf, $past(pwdata[7:0], 2)}) else $error("literal");
	a_ready_once: assert property (pready |=> !pready) else $error("ready");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error flag outside access");
	a_reset_quiet: assert property ($rose(presetn) |-> !mem_we && !pc_load && eff_addr == '0) else $error("reset");
	cover property (mem_we);
	cover property (pc_load);
	cover property (iw && !pwdata[8]);
	cover property (pslverr);
endmodule // sxd_monitor
bind sxd_stack_decode sxd_monitor sxd_monitor_inst (
	.pclk(pclk),
	.presetn(presetn),
	.pwrite(pwrite),
	.pready(pready),
	.pslverr(pslverr),
	.mem_we(mem_we),
	.dest_to_file(dest_to_file),
	.pc_load(pc_load),
	.paddr(paddr),
	.mem_wdata(mem_wdata),
	.pwdata(pwdata),
	.eff_addr(eff_addr)
);
`default_nettype wire

// file: sxd_stack_decode_tb_top.sv
// self-checking testbench for the stack extension decode block
`timescale 1ns/1ps
`default_nettype none
module sxd_stack_decode_tb_top;
	import sxd_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, mem_wdata;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, mem_we, dest_to_file, pc_load;
	logic [ADDR_W-1:0] mem_addr, eff_addr;
	logic [PC_W-1:0] pc_out;
	int mismatches = 0, cmp_count = 0;
	logic last_err = 1'b0;
	sxd_stack_decode sxd_stack_decode_inst (
		.pclk(pclk),
		.presetn(presetn),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.mem_we(mem_we),
		.mem_addr(mem_addr),
		.mem_wdata(mem_wdata),
		.eff_addr(eff_addr),
		.dest_to_file(dest_to_file),
		.pc_load(pc_load),
		.pc_out(pc_out)
	);
	always #12.5 pclk = ~pclk;
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		cmp_count++;
		mismatches += (g !== e);
		if (g !== e) $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
	endtask
	// reads compare d against data taken at the completing edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 9);
		if (!w) chk(prdata, d);
		last_err = pslverr;
		{psel, penable} <= 2'b00;
		mismatches += (n >= 9);
		if (n >= 9) end_of_test();
	endtask
	task automatic run(input logic [15:0] i);
		apb(1'b1, REG_INSN, {16'h0, i});
		@(posedge pclk) #1;
	endtask
	task automatic t_push();
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b1, REG_PTR2, 32'h1ec);
		run(16'hfa08);
		chk({mem_we, mem_addr, mem_wdata}, {1'b1, 12'h1ec, 8'h08});
		apb(1'b0, REG_PTR2, 32'h1eb);
	endtask
	task automatic t_sub();
		for (int f = 0; f < 3; f++) begin
			apb(1'b1, 8'(REG_PTR0 + 4 * f), 32'h3ff);
			run(16'he923 | 16'(f << 6));
			apb(1'b0, 8'(REG_PTR0 + 4 * f), 32'h3dc);
		end
	endtask
	task automatic t_ret();
		apb(1'b1, REG_RET_TOP, 32'h12345);
		run(16'he9e3);
		chk({pc_load, pc_out}, {1'b1, 21'h12345});
		apb(1'b0, REG_PTR2, 32'h3b9);
	endtask
	task automatic t_ea(input logic x, input logic [11:0] sp, input logic [15:0] i, input logic [11:0] e);
		apb(1'b1, REG_CTRL, {31'h0, x});
		apb(1'b1, REG_PTR2, {20'h0, sp});
		run(i);
		@(posedge pclk) #1;
		chk({dest_to_file, eff_addr}, {i[9], e});
	endtask
	// with the extension off the push opcode must leave memory and pointer alone
	task automatic t_ext_off();
		apb(1'b1, REG_CTRL, 32'h0);
		apb(1'b1, REG_PTR2, 32'h1ec);
		run(16'hfa08);
		chk(mem_we, 1'b0);
		apb(1'b0, REG_PTR2, 32'h1ec);
	endtask
	// unmapped or misaligned words are refused while pready stands
	task automatic t_err();
		apb(1'b1, REG_CTRL, 32'h0);
		chk(last_err, 1'b0);
		apb(1'b1, 8'h29, 32'h1);
		chk(last_err, 1'b1);
		apb(1'b0, 8'h28, 32'h0);
		chk(last_err, 1'b1);
		apb(1'b0, REG_CTRL, 32'h0);
	endtask
	// a mid-run reset must drop the extension enable and the stack pointer
	task automatic t_reset();
		apb(1'b1, REG_CTRL, 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_CTRL, 32'h0);
		apb(1'b0, REG_PTR2, 32'h0);
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_push();
		t_sub();
		t_ret();
		apb(1'b1, REG_BANK, 32'h5);
		t_ea(1'b1, 12'ha00, 16'h262c, 12'ha2c);
		t_ea(1'b1, 12'h000, 16'h8e0a, 12'h00a);
		t_ea(1'b1, 12'ha00, 16'h2460, 12'hf60);
		t_ea(1'b0, 12'ha00, 16'h252c, 12'h52c);
		t_ea(1'b0, 12'ha00, 16'h262c, 12'h02c);
		t_ext_off();
		t_err();
		t_reset();
		end_of_test();
	end
endmodule // sxd_stack_decode_tb_top
`default_nettype wire
